// [rtl/art_map.svh]
`ifndef ART_MAP_SVH
`define ART_MAP_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define ART_IDX_FIRST_CTL   8'h88
`define ART_IDX_READBACK    8'h89
`define ART_IDX_FIRST_LO    8'h8c
`define ART_IDX_FIRST_HI    8'h8d
`define ART_IDX_OPTION      8'h90
`define ART_IDX_THIRD_CTL   8'hc0
`define ART_IDX_SECOND_CTL  8'hc8
`define ART_IDX_SECOND_LO   8'hcc
`define ART_IDX_SECOND_HI   8'hcd
`define ART_IDX_THIRD_LO    8'hce
`define ART_IDX_THIRD_HI    8'hcf

// ****************************************
// field positions
// ****************************************
`define ART_FLAG_BIT        7
`define ART_CMP_BIT         6
`define ART_PS_HI           5
`define ART_PS_LO           4
`define ART_MODE_HI         3
`define ART_MODE_LO         2
`define ART_RUN_FIRST_BIT   2
`define ART_RUN_SECOND_BIT  1
`define ART_RUN_THIRD_BIT   1
`define ART_SRC_HI          1
`define ART_SRC_LO          0
`define ART_DOUBLE_BIT      4

// ****************************************
// values
// ****************************************
`define ART_RST_BYTE        8'h00
`define ART_RST_WORD        16'h0000
`define ART_CNT_MAX         16'hffff
`define ART_DIV8_MASK       8'h07
`define ART_DIV64_MASK      8'h3f
`define ART_DIV256_MASK     8'hff
`define ART_OSC_CODE_A      4'ha
`define ART_OSC_CODE_B      4'hd
`define ART_OSC_CODE_C      4'h3
`define ART_OSC_CODE_D      4'h6
`define ART_BAUD_DIV_NORM   5'h1f
`define ART_BAUD_DIV_DOUBLE 5'h0f
`define ART_HSIZE_WORD      3'h2

`endif

// [rtl/art_pkg.sv]
package art_pkg;
  typedef enum logic {trig_wait, trig_count} art_trig_e;
  typedef logic [15:0] art_word_t;
  typedef logic [1:0]  art_psel_t;
endpackage

// [rtl/art_timer_group.sv]
// Behaviour
// - first-timer clock source gated by option, power-down
// - hardware clears first flag on acknowledge
// - prescaler divides by 1, 8, 64, 256
// - first source: system, pin, low-speed oscillator
// - readback select picks count or reload
// - data writes go to load register
// - second timer counts, flags, reloads on rollover
// - high-byte write copies load into counter
// - second clock select: pin falling edge or system
// - setting run keeps counter contents
// - compare mode toggles second pin on overflow
// - baud mode reloads without raising flag
// - baud tick is overflow over 32 or 16
// - triggered mode waits edge, system clock only
// - running edge ignored or restarts per bit
// - third timer counts, flags, reloads on rollover
// - hardware clears second and third flags
// - first timer counts, flags, reloads on rollover
//
// Design decision made here: the AHB-Lite slave port.
`include "art_map.svh"
`timescale 1ns/1ns
module art_timer_group
  import art_pkg::*;
(
  input  wire logic        hclk,            // system clock, 20 MHz
  input  wire logic        hresetn,         // async reset, active low
  input  wire logic        hsel,            // slave select
  input  wire logic [31:0] haddr,           // byte address
  input  wire logic [1:0]  htrans,          // transfer type
  input  wire logic        hwrite,          // write when high
  input  wire logic [2:0]  hsize,           // transfer size
  input  wire logic [31:0] hwdata,          // write data
  input  wire logic        hready,          // bus ready
  output logic             hreadyout,       // slave ready
  output logic             hresp,           // always okay
  output logic [31:0]      hrdata,          // read data
  input  wire logic        power_down,      // cpu power-down mode
  input  wire logic        lowspeed_clk,    // low-speed oscillator
  input  wire logic        first_timer_pin, // first timer pin input
  input  wire logic        second_pin_in,   // second timer pin level
  output logic             second_pin_out,  // second timer pin drive
  output logic             second_pin_oe_n, // low while driving
  output logic             first_pullup_en, // pull-up for first pin
  output logic             second_pullup_en,// pull-up for second pin
  input  wire logic [2:0]  flag_ack,        // interrupt taken, per timer
  output logic [2:0]       timer_flag,      // overflow flags
  output logic             baud_tick        // serial bit-rate pulse
);

  // ****************************************
  // decode helpers
  // ****************************************
  function automatic logic pre_hit(input art_psel_t sel, input logic [7:0] c);
    logic [7:0] m;
    m = `ART_RST_BYTE;
    case (sel)
      2'h1:    m = `ART_DIV8_MASK;
      2'h2:    m = `ART_DIV64_MASK;
      2'h3:    m = `ART_DIV256_MASK;
      default: m = `ART_RST_BYTE;
    endcase
    return (c & m) == m;
  endfunction

  function automatic logic idx_hit(input logic [7:0] a, input logic [7:0] idx);
    return a == idx;
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic        wph_q, rph_q, dmap_q;
  logic [7:0]  didx_q;
  logic [31:0] hrdata_q;
  art_word_t   cnt_q [3];
  art_word_t   load_q [3];
  logic [7:0]  pre_q [3];
  art_psel_t   ps_q [3];
  logic [2:0]  run_q, flag_q;
  logic [1:0]  src1_q, mode_q, rbs_q;
  logic        src2_q, cmp_q;
  logic [4:0]  opt_q;
  art_trig_e   trig_q, trig_d;
  logic [2:0]  p1_s_q, p2_s_q, ls_s_q;
  logic        pin_out_q, pin_oe_n_q, baud_tick_q;
  logic [4:0]  baud_div_q;

  // ****************************************
  // bus slave
  // ****************************************
  // reads take one wait cycle so a write just before is always visible
  wire addr_ok = hsel && htrans[1] && hready && hsize == `ART_HSIZE_WORD;
  wire map_ok  = haddr[31:10] == 22'h0 && haddr[1:0] == 2'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wph_q  <= 1'b0;
      rph_q  <= 1'b0;
      dmap_q <= 1'b0;
      didx_q <= `ART_RST_BYTE;
    end else begin
      wph_q <= addr_ok && hwrite;
      rph_q <= addr_ok && !hwrite;
      if (addr_ok) begin
        dmap_q <= map_ok;
        didx_q <= haddr[9:2];
      end
    end
  end

  wire [7:0] wb = hwdata[7:0];
  // write strobes, valid in the data phase
  wire wr = wph_q && dmap_q;
  wire we_ctl1 = wr && idx_hit(didx_q, `ART_IDX_FIRST_CTL);
  wire we_rbs  = wr && idx_hit(didx_q, `ART_IDX_READBACK);
  wire we_opt  = wr && idx_hit(didx_q, `ART_IDX_OPTION);
  wire we_ctl2 = wr && idx_hit(didx_q, `ART_IDX_SECOND_CTL);
  wire we_ctl3 = wr && idx_hit(didx_q, `ART_IDX_THIRD_CTL);
  wire [2:0] lowr_w = {wr && idx_hit(didx_q, `ART_IDX_THIRD_LO),
                       wr && idx_hit(didx_q, `ART_IDX_SECOND_LO),
                       wr && idx_hit(didx_q, `ART_IDX_FIRST_LO)};
  wire [2:0] hiwr_w = {wr && idx_hit(didx_q, `ART_IDX_THIRD_HI),
                       wr && idx_hit(didx_q, `ART_IDX_SECOND_HI),
                       wr && idx_hit(didx_q, `ART_IDX_FIRST_HI)};
  wire [2:0] ctlwr_w = {we_ctl3, we_ctl2, we_ctl1};

  // read views: readback select per timer, second timer always shows count
  wire art_word_t view0 = rbs_q[0] ? load_q[0] : cnt_q[0];
  wire art_word_t view1 = cnt_q[1];
  wire art_word_t view2 = rbs_q[1] ? load_q[2] : cnt_q[2];
  wire [7:0] rd_ctl1 = {flag_q[0], 1'b0, ps_q[0], 1'b0, run_q[0], src1_q};
  wire [7:0] rd_ctl2 = {flag_q[1], cmp_q, ps_q[1], mode_q, run_q[1], src2_q};
  wire [7:0] rd_ctl3 = {flag_q[2], 1'b0, ps_q[2], 2'h0, run_q[2], 1'b0};
  wire [7:0] rd_byte =
    !dmap_q                                   ? `ART_RST_BYTE :
    idx_hit(didx_q, `ART_IDX_FIRST_CTL)       ? rd_ctl1 :
    idx_hit(didx_q, `ART_IDX_READBACK)        ? {6'h0, rbs_q} :
    idx_hit(didx_q, `ART_IDX_FIRST_LO)        ? view0[7:0] :
    idx_hit(didx_q, `ART_IDX_FIRST_HI)        ? view0[15:8] :
    idx_hit(didx_q, `ART_IDX_OPTION)          ? {3'h0, opt_q} :
    idx_hit(didx_q, `ART_IDX_THIRD_CTL)       ? rd_ctl3 :
    idx_hit(didx_q, `ART_IDX_SECOND_CTL)      ? rd_ctl2 :
    idx_hit(didx_q, `ART_IDX_SECOND_LO)       ? view1[7:0] :
    idx_hit(didx_q, `ART_IDX_SECOND_HI)       ? view1[15:8] :
    idx_hit(didx_q, `ART_IDX_THIRD_LO)        ? view2[7:0] :
    idx_hit(didx_q, `ART_IDX_THIRD_HI)        ? view2[15:8] : `ART_RST_BYTE;

  // read data captured during the wait cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0;
    end else if (rph_q) begin
      hrdata_q <= {24'h0, rd_byte};
    end
  end

  assign hreadyout = !rph_q;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;

  // ****************************************
  // control registers
  // ****************************************
  // triggered modes force the second clock select to the system clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q  <= 3'h0;
      src1_q <= 2'h0;
      src2_q <= 1'b0;
      mode_q <= 2'h0;
      cmp_q  <= 1'b0;
      rbs_q  <= 2'h0;
      opt_q  <= 5'h0;
      ps_q   <= '{default: 2'h0};
    end else begin
      if (we_ctl1) begin
        ps_q[0]  <= wb[`ART_PS_HI:`ART_PS_LO];
        run_q[0] <= wb[`ART_RUN_FIRST_BIT];
        src1_q   <= wb[`ART_SRC_HI:`ART_SRC_LO];
      end
      if (we_ctl2) begin
        ps_q[1]  <= wb[`ART_PS_HI:`ART_PS_LO];
        run_q[1] <= wb[`ART_RUN_SECOND_BIT];
        mode_q   <= wb[`ART_MODE_HI:`ART_MODE_LO];
        cmp_q    <= wb[`ART_CMP_BIT];
        src2_q   <= wb[`ART_SRC_LO] && !wb[`ART_MODE_HI];
      end
      if (we_ctl3) begin
        ps_q[2]  <= wb[`ART_PS_HI:`ART_PS_LO];
        run_q[2] <= wb[`ART_RUN_THIRD_BIT];
      end
      if (we_rbs) rbs_q <= wb[1:0];
      if (we_opt) opt_q <= wb[4:0];
    end
  end

  // ****************************************
  // pin and oscillator synchronisers
  // ****************************************
  // stage 0 feeds only stage 1; pins start at their pulled-up idle level
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      p1_s_q <= 3'h7;
      p2_s_q <= 3'h7;
      ls_s_q <= 3'h0;
    end else begin
      p1_s_q <= {p1_s_q[1:0], first_timer_pin};
      p2_s_q <= {p2_s_q[1:0], second_pin_in};
      ls_s_q <= {ls_s_q[1:0], lowspeed_clk};
    end
  end

  wire p1_fall = p1_s_q[2] && !p1_s_q[1];
  wire p2_fall = p2_s_q[2] && !p2_s_q[1];
  wire p2_rise = !p2_s_q[2] && p2_s_q[1];
  wire ls_rise = !ls_s_q[2] && ls_s_q[1];

  // ****************************************
  // clock sources and modes
  // ****************************************
  wire opt_ok = opt_q[3:0] == `ART_OSC_CODE_A || opt_q[3:0] == `ART_OSC_CODE_B ||
                opt_q[3:0] == `ART_OSC_CODE_C || opt_q[3:0] == `ART_OSC_CODE_D;
  // system clock source stops in power-down; pin and oscillator keep going
  wire tick0 = src1_q == 2'h0 ? !power_down :
               src1_q == 2'h1 ? p1_fall :
               src1_q == 2'h2 ? (opt_ok && ls_rise) : 1'b0;
  wire trig_mode = mode_q[1];
  wire baud_mode = mode_q == 2'h1;
  wire cmp_mode  = mode_q == 2'h0 && cmp_q && !src2_q;
  wire tick1 = (src2_q && !trig_mode) ? p2_fall : !power_down;
  wire tick2 = !power_down;
  wire act_edge = mode_q[0] ? p2_fall : p2_rise;

  wire [2:0] tick_w = {tick2, tick1, tick0};
  wire [2:0] act_w;
  wire [2:0] inc_w, ovf_w, restart_w, set_en_w;
  assign act_w[0] = run_q[0];
  assign act_w[1] = run_q[1] && (!trig_mode || trig_q == trig_count);
  assign act_w[2] = run_q[2];
  // a running edge restarts only with the retrigger bit set
  assign restart_w[0] = 1'b0;
  assign restart_w[1] = trig_q == trig_count && run_q[1] && trig_mode &&
                        act_edge && cmp_q && !ovf_w[1];
  assign restart_w[2] = 1'b0;
  assign set_en_w = {1'b1, !baud_mode, 1'b1};

  // trigger sequencer for the second timer
  always_comb begin
    trig_d = trig_q;
    case (trig_q)
      trig_wait: begin
        if (run_q[1] && trig_mode && act_edge) trig_d = trig_count;
      end
      trig_count: begin
        if (!run_q[1] || !trig_mode || ovf_w[1]) trig_d = trig_wait;
      end
      default: trig_d = trig_wait;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) trig_q <= trig_wait;
    else          trig_q <= trig_d;
  end

  // ****************************************
  // prescaler, counter, load and flag per timer
  // ****************************************
  generate
    for (genvar g = 0; g < 3; g++) begin : g_tmr
      assign inc_w[g] = tick_w[g] && act_w[g] && pre_hit(ps_q[g], pre_q[g]);
      assign ovf_w[g] = inc_w[g] && cnt_q[g] == `ART_CNT_MAX;

      // run does not load or clear the counter, only gates the prescaler and the count step
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pre_q[g] <= `ART_RST_BYTE;
        end else if (restart_w[g]) begin
          pre_q[g] <= `ART_RST_BYTE;
        end else if (tick_w[g] && act_w[g]) begin
          pre_q[g] <= pre_q[g] + 8'h1;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          cnt_q[g] <= `ART_RST_WORD;
        end else if (hiwr_w[g]) begin
          cnt_q[g] <= {wb, load_q[g][7:0]};
        end else if (restart_w[g] || ovf_w[g]) begin
          cnt_q[g] <= load_q[g];
        end else if (inc_w[g]) begin
          cnt_q[g] <= cnt_q[g] + 16'h1;
        end
      end

      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          load_q[g] <= `ART_RST_WORD;
        end else begin
          if (lowr_w[g]) load_q[g][7:0]  <= wb;
          if (hiwr_w[g]) load_q[g][15:8] <= wb;
        end
      end

      // hardware set wins over both the software write and the acknowledge
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          flag_q[g] <= 1'b0;
        end else if (ovf_w[g] && set_en_w[g]) begin
          flag_q[g] <= 1'b1;
        end else if (ctlwr_w[g]) begin
          flag_q[g] <= wb[`ART_FLAG_BIT];
        end else if (flag_ack[g]) begin
          flag_q[g] <= 1'b0;
        end
      end
    end
  endgenerate

  // ****************************************
  // compare pin and baud tick
  // ****************************************
  // pin drive is registered so the enable never glitches on a mode write
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out_q  <= 1'b0;
      pin_oe_n_q <= 1'b1;
    end else begin
      pin_oe_n_q <= !cmp_mode;
      if (cmp_mode && ovf_w[1]) pin_out_q <= !pin_out_q;
    end
  end

  // serial port samples 16 times per bit; doubling halves the divider
  wire [4:0] baud_lim = opt_q[`ART_DOUBLE_BIT] ? `ART_BAUD_DIV_DOUBLE : `ART_BAUD_DIV_NORM;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      baud_div_q  <= 5'h0;
      baud_tick_q <= 1'b0;
    end else begin
      baud_tick_q <= 1'b0;
      if (!baud_mode) begin
        baud_div_q <= 5'h0;
      end else if (ovf_w[1]) begin
        if (baud_div_q >= baud_lim) begin
          baud_div_q  <= 5'h0;
          baud_tick_q <= 1'b1;
        end else begin
          baud_div_q <= baud_div_q + 5'h1;
        end
      end
    end
  end

  assign second_pin_out   = pin_out_q;
  assign second_pin_oe_n  = pin_oe_n_q;
  assign first_pullup_en  = src1_q == 2'h1;
  assign second_pullup_en = src2_q;
  assign timer_flag       = flag_q;
  assign baud_tick        = baud_tick_q;

  // ****************************************
  // assertions
  // ****************************************
  a_first_reload: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_w[0] && !hiwr_w[0] |=> cnt_q[0] == $past(load_q[0]))
    else $error("first timer did not reload on rollover");
  a_flag_set: assert property (@(posedge hclk) disable iff (!hresetn)
    ovf_w[2] |=> flag_q[2])
    else $error("third flag not set on overflow");
  a_baud_noflag: assert property (@(posedge hclk) disable iff (!hresetn)
    baud_mode && ovf_w[1] && !flag_q[1] && !we_ctl2 |=> !flag_q[1])
    else $error("baud mode overflow raised the flag");
  a_high_copy: assert property (@(posedge hclk) disable iff (!hresetn)
    hiwr_w[1] |=> cnt_q[1] == load_q[1])
    else $error("high byte write did not copy load");
  a_pin_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    cmp_mode && ovf_w[1] |=> second_pin_out != $past(second_pin_out) && !second_pin_oe_n)
    else $error("compare overflow did not toggle pin");
  a_trig_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    trig_mode && trig_q == trig_wait && !hiwr_w[1] |=> cnt_q[1] == $past(cnt_q[1]))
    else $error("triggered timer counted while waiting");
  a_src_invalid: assert property (@(posedge hclk) disable iff (!hresetn)
    src1_q == 2'h2 && !opt_ok |-> !inc_w[0])
    else $error("first timer ran from disabled oscillator");
  a_div8_step: assert property (@(posedge hclk) disable iff (!hresetn)
    inc_w[0] && ps_q[0] == 2'h1 |-> pre_q[0][2:0] == 3'h7)
    else $error("prescaler by 8 stepped at wrong phase");
  a_read_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    addr_ok && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read data phase not two cycles");
  a_retrig: assert property (@(posedge hclk) disable iff (!hresetn)
    restart_w[1] && !hiwr_w[1] |=> cnt_q[1] == $past(load_q[1]) && pre_q[1] == 8'h0)
    else $error("retrigger did not restart timer");

endmodule

// [testbench/art_pin_model.sv]
`timescale 1ns/1ns
// ****************************************
// far-side pin source
// ****************************************
module art_pin_model (
  input  wire logic hclk, // system clock
  input  wire logic want, // level the bench asks for
  output logic      pin,  // level driven on the pin
  output logic      slow  // free-running low-speed oscillator
);
  int hold;
  int div;
  // a level must stand 5 cycles before it may change, so edges stay slow
  always @(posedge hclk) begin
    hold <= (pin != want && hold >= 4) ? 0 : hold + 1;
    if (pin != want && hold >= 4) pin <= want;
  end
  // the oscillator runs free and never stops between uses
  always @(posedge hclk) begin
    div <= div + 1;
    if (div % 16 == 15) slow <= ~slow;
  end
  initial begin
    pin = 1'b1;
    slow = 1'b0;
    hold = 0;
    div = 0;
  end
endmodule

// [testbench/art_timer_group_bench.sv]
`timescale 1ns/1ns
module art_timer_group_bench
  import art_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, want, mpin, slow, pdn;
  logic        hreadyout, hresp, second_pin_out, second_pin_oe_n, baud_tick;
  logic        first_pullup_en, second_pullup_en;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, flag_ack, timer_flag;
  logic [7:0]  rd;
  int          error_cnt, check_count, cyc, n;
  int          divs [4] = '{1, 8, 64, 256};
  logic [7:0]  regs [8] = '{8'h88, 8'h89, 8'h8c, 8'h8d, 8'hc0, 8'hc8, 8'hcc, 8'hcd};
  // the pin level: design drives only while its enable is low
  wire         pin2 = second_pin_oe_n ? mpin : second_pin_out;
  wire  [4:0]  ev = {second_pin_out, baud_tick, timer_flag};

  art_timer_group u_art_timer_group (
    .hclk             (hclk),
    .hresetn          (hresetn),
    .hsel             (hsel),
    .haddr            (haddr),
    .htrans           (htrans),
    .hwrite           (hwrite),
    .hsize            (hsize),
    .hwdata           (hwdata),
    .hready           (hreadyout),
    .hreadyout        (hreadyout),
    .hresp            (hresp),
    .hrdata           (hrdata),
    .power_down       (pdn),
    .lowspeed_clk     (slow),
    .first_timer_pin  (mpin),
    .second_pin_in    (pin2),
    .second_pin_out   (second_pin_out),
    .second_pin_oe_n  (second_pin_oe_n),
    .first_pullup_en  (first_pullup_en),
    .second_pullup_en (second_pullup_en),
    .flag_ack         (flag_ack),
    .timer_flag       (timer_flag),
    .baud_tick        (baud_tick)
  );
  art_pin_model u_art_pin_model (
    .hclk (hclk),
    .want (want),
    .pin  (mpin),
    .slow (slow)
  );

  // ****************************************
  // bus and check tasks
  // ****************************************
  // one single word transfer; the wait for hready has no fixed length
  task automatic bus(input logic [7:0] idx, input logic wr, input logic [7:0] wd);
    haddr  <= {22'h0, idx, 2'h0};
    hwrite <= wr;
    htrans <= 2'h2;
    hsel   <= 1'b1;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= {24'h0, wd};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata[7:0];
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
    bus(idx, 1'b0, 8'h00);
    chk({8'h00, rd}, {8'h00, exp}, "register read");
    chk(16'(hresp), 16'h0, "bus response");
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(idx, 1'b1, d);
  endtask
  // low byte first: the high write copies the whole load word
  task automatic load(input logic [7:0] lo, input art_word_t v);
    wr(lo, v[7:0]);
    wr(8'(lo + 8'h01), v[15:8]);
  endtask
  // cycles between two rises of an event; the first gap is skipped as
  // the prescaler phase at start is unknown. flags are acknowledged.
  task automatic span(input int i, output int gap);
    int   t [$];
    logic p;
    p = ev[i];
    while (t.size() < 3) begin
      @(posedge hclk);
      if (ev[i] === 1'b1 && p !== 1'b1) t.push_back(cyc);
      p = ev[i];
      flag_ack <= (i < 3 && ev[i] === 1'b1) ? 3'(1 << i) : 3'h0;
    end
    // let the last acknowledge act, then release it
    @(posedge hclk);
    flag_ack <= 3'h0;
    gap = t[2] - t[1];
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  always #25 hclk = ~hclk;
  always @(posedge hclk) cyc <= cyc + 1;
  initial begin
    #1000000;
    error_cnt++;
    $display("wrong value at %0t: timeout", $time);
    test_done();
  end
  initial begin
    {hclk, hresetn, hsel, hwrite, htrans, haddr, hwdata, pdn} = '0;
    {flag_ack, cyc, error_cnt, check_count} = '0;
    hsize = 3'h2;
    want = 1'b1;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    foreach (regs[i]) rdchk(regs[i], 8'h00);
    wr(8'h10, 8'hff);
    rdchk(8'h10, 8'h00);
    $display("test reset values done");
    load(8'h8c, 16'hfffe);
    rdchk(8'h8d, 8'hff);
    rdchk(8'h8c, 8'hfe);
    wr(8'h8c, 8'h34);
    rdchk(8'h8c, 8'hfe);
    wr(8'h89, 8'h01);
    rdchk(8'h8c, 8'h34);
    wr(8'h89, 8'h00);
    load(8'h8c, 16'hff00);
    wr(8'h88, 8'h04);
    span(0, n);
    chk(16'(n), 16'd256, "first period");
    wr(8'h88, 8'h80);
    rdchk(8'h88, 8'h80);
    flag_ack <= 3'h1;
    @(posedge hclk);
    flag_ack <= 3'h0;
    @(posedge hclk);
    chk(16'(timer_flag[0]), 16'h0, "flag acknowledge");
    $display("test first timer done");
    load(8'hcc, 16'hffff);
    for (int p = 1; p < 4; p++) begin
      wr(8'hc8, {2'h0, 2'(p), 4'h2});
      span(1, n);
      chk(16'(n), 16'(divs[p]), "prescaled period");
    end
    wr(8'h88, 8'h01);
    wr(8'hc8, 8'h01);
    @(posedge hclk);
    chk(16'({first_pullup_en, second_pullup_en}), 16'h3, "pull-ups");
    $display("test prescaler done");
    // first timer from its pin: two falling edges roll fffe over
    load(8'h8c, 16'hfffe);
    wr(8'h88, 8'h05);
    repeat (2) begin
      want <= 1'b0;
      repeat (10) @(posedge hclk);
      want <= 1'b1;
      repeat (10) @(posedge hclk);
    end
    chk(16'(timer_flag[0]), 16'h1, "pin clock overflow");
    // low-speed oscillator keeps counting in power-down, system clock stops
    wr(8'h88, 8'h00);
    load(8'h8c, 16'hfffe);
    wr(8'h90, 8'h0a);
    pdn <= 1'b1;
    wr(8'h88, 8'h06);
    span(0, n);
    chk(16'(n), 16'd64, "oscillator in power-down");
    wr(8'h90, 8'h00);
    wr(8'h88, 8'h06);
    repeat (100) @(posedge hclk);
    chk(16'(timer_flag[0]), 16'h0, "oscillator disabled");
    wr(8'h88, 8'h04);
    repeat (100) @(posedge hclk);
    chk(16'(timer_flag[0]), 16'h0, "system clock in power-down");
    wr(8'h88, 8'h00);
    pdn <= 1'b0;
    $display("test clock sources done");
    load(8'hcc, 16'hfffe);
    wr(8'hc8, 8'h42);
    span(4, n);
    chk(16'(n), 16'd4, "pin toggle period");
    chk(16'(second_pin_oe_n), 16'h0, "pin drive");
    // stop first: the flag may be set at this edge, the next control write clears it
    wr(8'hc8, 8'h00);
    load(8'hcc, 16'hffff);
    for (int d = 0; d < 2; d++) begin
      wr(8'h90, d ? 8'h10 : 8'h00);
      wr(8'hc8, 8'h06);
      span(3, n);
      chk(16'(n), d ? 16'd16 : 16'd32, "baud period");
      chk(16'(timer_flag[1]), 16'h0, "baud flag");
    end
    $display("test compare and baud done");
    // rising mode first, then falling; the pin starts low for rising, high for falling
    for (int m = 2; m < 4; m++) begin
      wr(8'hc8, 8'h00);
      want <= (m == 3);
      load(8'hcc, 16'hfff0);
      wr(8'hc8, {4'h0, 2'(m), 2'h2});
      repeat (40) @(posedge hclk);
      chk(16'(timer_flag[1]), 16'h0, "waits for edge");
      want <= (m == 2);
      repeat (40) @(posedge hclk);
      chk(16'(timer_flag[1]), 16'h1, "edge starts count");
      rdchk(8'hcd, 8'hff);
      rdchk(8'hcc, 8'hf0);
    end
    // retrigger on: a second falling edge while counting restarts from load
    wr(8'hc8, 8'h00);
    want <= 1'b1;
    load(8'hcc, 16'hff00);
    wr(8'hc8, 8'h4e);
    want <= 1'b0;
    repeat (100) @(posedge hclk);
    want <= 1'b1;
    repeat (10) @(posedge hclk);
    want <= 1'b0;
    repeat (190) @(posedge hclk);
    chk(16'(timer_flag[1]), 16'h0, "edge restarts count");
    repeat (100) @(posedge hclk);
    chk(16'(timer_flag[1]), 16'h1, "restarted overflow");
    $display("test triggered done");
    wr(8'hc8, 8'h00);
    load(8'hce, 16'hff00);
    wr(8'hc0, 8'h02);
    span(2, n);
    chk(16'(n), 16'd256, "third period");
    wr(8'hc0, 8'h00);
    wr(8'hce, 8'h12);
    wr(8'h89, 8'h02);
    rdchk(8'hce, 8'h12);
    $display("test third timer done");
    test_done();
  end
endmodule
